// ==== hdl/dsp_pkg.sv ====
// Purpose: Shared constants and carriers for the direct setpoint positioner
// Assumes: Classic Wishbone, 32-bit data, byte addressed
// Notes: Offsets are word aligned
package dsp_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POS = 8'h04;
  localparam logic [7:0] OFS_VEL = 8'h08;
  localparam logic [7:0] OFS_OVR = 8'h0C;
  localparam logic [7:0] OFS_ADAPT = 8'h10;
  localparam logic [7:0] OFS_SRC = 8'h14;
  localparam logic [7:0] OFS_FIX_BASE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_TARGET = 8'h34;
  localparam logic [7:0] OFS_VCMD = 8'h38;
  localparam logic [7:0] OFS_PROF = 8'h3C;
  // ****************************************
  // Control bit positions
  // ****************************************
  localparam int B_ENABLE = 0;
  localparam int B_SETUP = 1;
  localparam int B_ISTOP_N = 2;
  localparam int B_DISCARD_N = 3;
  localparam int B_ABS = 4;
  localparam int B_DIR_POS = 6;
  localparam int B_DIR_NEG = 7;
  localparam int B_ACCEPT = 8;
  localparam int B_CONT = 9;
  localparam int B_REFERENCED = 10;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_CTRL = 32'h0000_000C;
  localparam logic [31:0] RST_OVR = 32'h0064_0064;
  localparam logic [7:0] RST_VOVR = 8'h64;
  localparam logic [7:0] PERCENT_FULL = 8'h64;
  // ****************************************
  // Mode adaptation digit codes
  // ****************************************
  localparam logic [3:0] ADAPT_ABS = 4'h0;
  localparam logic [3:0] ADAPT_REL = 4'h1;
  localparam logic [3:0] ADAPT_ROT_POS = 4'h2;
  localparam logic [3:0] ADAPT_ROT_NEG = 4'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_STOP = 4'b1000
  } dsp_state_e;

  typedef struct packed {
    logic enable;
    logic setup;
    logic istop_n;
    logic discard_n;
    logic absolute;
    logic dir_pos;
    logic dir_neg;
    logic accept;
    logic cont;
    logic referenced;
  } dsp_ctrl_s;

  typedef struct packed {
    logic [15:0] vel;
    logic [7:0] accel;
    logic [7:0] decel;
  } dsp_prof_s;
endpackage

// ==== hdl/dsp_fix_mem.sv ====
// Purpose: Small store of the four fixed setpoint values
// Assumes: One write port and one registered read port
// Notes: Read data lags address by one clock
`timescale 1ns/1ns
module dsp_fix_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_ff
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = mem_ff[raddr];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Storage has no reset; software loads it before use
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end
endmodule

// ==== hdl/dsp_core.sv ====
// Purpose: Direct setpoint command decoding for the positioner
// Assumes: Classic Wishbone slave, 125 MHz clk_sys
// Notes: Command decode only; no profile generator
// Operation
// R1 - Controller holds enable high throughout
// R2 - Mode bit picks positioning or set-up
// R3 - Set-up to positioning switch while moving
// R4 - Intermediate stop holds, job stays resumable
// R5 - Discard stops and kills the job
// R6 - Type bit: relative/absolute, absolute needs reference
// R7 - Set-up direction from bits six, seven
// R8 - Equal direction bits stop the axis
// R9 - Edge mode starts on accept rise
// R10 - Continuous mode tracks position setpoint
// R11 - Continuous mode forbids relative positioning
// R12 - Adaptation digit: 0 absolute, 1 relative
// R13 - Adaptation digit: 2/3 rotary direction
// R14 - Zero adaptation word uses control bits
// R15 - Overrides scale velocity and ramps
// R16 - Setpoints may source stored fixed values
// R17 - Accept edge from previous-cycle compare
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module dsp_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Motion command outputs
  output logic move_active,
  output logic [31:0] target_pos,
  output logic signed [31:0] vel_cmd,
  output logic [7:0] accel_cmd,
  output logic [7:0] decel_cmd,
  output logic start_pulse,
  output logic cmd_fault
);
  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] pos_ff, nxt_pos;
  logic [31:0] vel_ff, nxt_vel;
  logic [31:0] ovr_ff, nxt_ovr;
  logic [15:0] adapt_ff, nxt_adapt;
  logic [3:0] src_ff, nxt_src;
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic [31:0] rd_ff, nxt_rd;
  logic [31:0] wmask;
  logic req, hit_fix, mapped;
  logic [31:0] fix_q;
  logic [1:0] fix_idx;
  dsp_pkg::dsp_ctrl_s c;
  dsp_pkg::dsp_state_e st_ff, nxt_st;
  logic job_valid_ff, nxt_job_valid;

  assign req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
  assign hit_fix = wb_adr_i[7:4] == dsp_pkg::OFS_FIX_BASE[7:4];
  assign fix_idx = wb_adr_i[3:2];

  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    case (wb_adr_i)
      dsp_pkg::OFS_CTRL, dsp_pkg::OFS_POS, dsp_pkg::OFS_VEL,
      dsp_pkg::OFS_OVR, dsp_pkg::OFS_ADAPT, dsp_pkg::OFS_SRC,
      dsp_pkg::OFS_STATUS, dsp_pkg::OFS_TARGET, dsp_pkg::OFS_VCMD,
      dsp_pkg::OFS_PROF: mapped = 1'b1;
      default: mapped = hit_fix && wb_adr_i[1:0] == 2'h0;
    endcase
  end

  // Fixed setpoint store: position, velocity, accel, decel
  dsp_fix_mem #(.WIDTH(32), .DEPTH(4)) u_fix (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .we(req && wb_we_i && hit_fix && mapped),
    .waddr(fix_idx),
    .wdata(wb_dat_i),
    .raddr(fix_idx),
    .rdata_ff(fix_q)
  );

  // Fixed-store reads need one wait state for the registered memory
  logic fix_wait_ff, nxt_fix_wait;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pos = pos_ff;
    nxt_vel = vel_ff;
    nxt_ovr = ovr_ff;
    nxt_adapt = adapt_ff;
    nxt_src = src_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    nxt_rd = rd_ff;
    nxt_fix_wait = 1'b0;
    if (req && !mapped) begin
      nxt_err = 1'b1;
    end else if (req && hit_fix && !wb_we_i && !fix_wait_ff) begin
      nxt_fix_wait = 1'b1;
    end else if (req) begin
      nxt_ack = 1'b1;
      if (wb_we_i) begin
        case (wb_adr_i)
          dsp_pkg::OFS_CTRL:
            nxt_ctrl = (ctrl_ff & ~wmask) | (wb_dat_i & wmask);
          dsp_pkg::OFS_POS: nxt_pos = (pos_ff & ~wmask) | (wb_dat_i & wmask);
          dsp_pkg::OFS_VEL: nxt_vel = (vel_ff & ~wmask) | (wb_dat_i & wmask);
          dsp_pkg::OFS_OVR: nxt_ovr = (ovr_ff & ~wmask) | (wb_dat_i & wmask);
          dsp_pkg::OFS_ADAPT:
            nxt_adapt = (adapt_ff & ~wmask[15:0]) |
                        (wb_dat_i[15:0] & wmask[15:0]);
          dsp_pkg::OFS_SRC:
            nxt_src = wb_sel_i[0] ? wb_dat_i[3:0] : src_ff;
          default: nxt_src = src_ff;
        endcase
      end else begin
        case (wb_adr_i)
          dsp_pkg::OFS_CTRL: nxt_rd = ctrl_ff;
          dsp_pkg::OFS_POS: nxt_rd = pos_ff;
          dsp_pkg::OFS_VEL: nxt_rd = vel_ff;
          dsp_pkg::OFS_OVR: nxt_rd = ovr_ff;
          dsp_pkg::OFS_ADAPT: nxt_rd = {16'h0000, adapt_ff};
          dsp_pkg::OFS_SRC: nxt_rd = {28'h0000000, src_ff};
          dsp_pkg::OFS_STATUS:
            nxt_rd = {24'h000000, 2'h0, cmd_fault, job_valid_ff, st_ff};
          dsp_pkg::OFS_TARGET: nxt_rd = target_pos;
          dsp_pkg::OFS_VCMD: nxt_rd = vel_cmd;
          dsp_pkg::OFS_PROF: nxt_rd = {16'h0000, accel_cmd, decel_cmd};
          default: nxt_rd = fix_q;
        endcase
      end
    end
  end

  // ****************************************
  // Setpoint sources and mode decode
  // ****************************************
  logic [31:0] pos_sel, vel_sel, ovr_sel;
  logic [31:0] fix_pos_ff, fix_vel_ff, fix_ovr_ff;
  logic [31:0] nxt_fix_pos, nxt_fix_vel, nxt_fix_ovr;
  logic [3:0] digit;
  logic absolute, rot_dir, rot_neg, edge_start, dir_stop, abs_ok;
  logic accept_q_ff, nxt_accept_q;

  // Shadow copies of the fixed store, captured on write
  always_comb begin
    nxt_fix_pos = fix_pos_ff;
    nxt_fix_vel = fix_vel_ff;
    nxt_fix_ovr = fix_ovr_ff;
    if (req && wb_we_i && hit_fix && mapped) begin
      case (fix_idx)
        2'h0: nxt_fix_pos = wb_dat_i;
        2'h1: nxt_fix_vel = wb_dat_i;
        2'h2: nxt_fix_ovr = {fix_ovr_ff[31:8], wb_dat_i[7:0]};
        default: nxt_fix_ovr = {fix_ovr_ff[31:24], wb_dat_i[7:0],
                                fix_ovr_ff[15:0]};
      endcase
    end
  end

  always_comb begin
    c = '{enable: ctrl_ff[dsp_pkg::B_ENABLE], setup: ctrl_ff[dsp_pkg::B_SETUP],
          istop_n: ctrl_ff[dsp_pkg::B_ISTOP_N],
          discard_n: ctrl_ff[dsp_pkg::B_DISCARD_N],
          absolute: ctrl_ff[dsp_pkg::B_ABS],
          dir_pos: ctrl_ff[dsp_pkg::B_DIR_POS],
          dir_neg: ctrl_ff[dsp_pkg::B_DIR_NEG],
          accept: ctrl_ff[dsp_pkg::B_ACCEPT], cont: ctrl_ff[dsp_pkg::B_CONT],
          referenced: ctrl_ff[dsp_pkg::B_REFERENCED]};
    pos_sel = src_ff[0] ? fix_pos_ff : pos_ff; // R16
    vel_sel = src_ff[1] ? fix_vel_ff : vel_ff; // R16
    ovr_sel = ovr_ff;
    if (src_ff[2]) ovr_sel[7:0] = fix_ovr_ff[7:0]; // R16
    if (src_ff[3]) ovr_sel[23:16] = fix_ovr_ff[23:16]; // R16
    digit = adapt_ff[7:4];
    rot_dir = 1'b0;
    rot_neg = 1'b0;
    if (adapt_ff == 16'h0000) begin
      absolute = c.absolute; // R14 R6
    end else begin
      absolute = digit != dsp_pkg::ADAPT_REL; // R12
      rot_dir = digit == dsp_pkg::ADAPT_ROT_POS || // R13
                digit == dsp_pkg::ADAPT_ROT_NEG;
      rot_neg = digit == dsp_pkg::ADAPT_ROT_NEG; // R13
    end
    abs_ok = !absolute || c.referenced; // R6
    nxt_accept_q = c.accept;
    edge_start = c.accept && !accept_q_ff && !c.cont; // R17 R9
    dir_stop = c.dir_pos == c.dir_neg; // R8
  end

  // ****************************************
  // Job state machine
  // ****************************************
  logic [31:0] tgt_ff, nxt_tgt;
  logic signed [31:0] vcmd_ff, nxt_vcmd;
  logic [7:0] acc_ff, nxt_acc, dec_ff, nxt_dec;
  logic start_ff, nxt_start, fault_ff, nxt_fault;
  logic [39:0] vprod;
  logic [15:0] aprod, dprod;
  logic [31:0] vscaled;

  always_comb begin
    // R15 Overrides in percent of the profile
    vprod = 40'(vel_sel) * 40'(ovr_sel[15:8]);
    vscaled = 32'(vprod / 40'(dsp_pkg::PERCENT_FULL));
    aprod = 16'(ovr_sel[7:0]) * 16'(dsp_pkg::PERCENT_FULL);
    dprod = 16'(ovr_sel[23:16]) * 16'(dsp_pkg::PERCENT_FULL);
    nxt_acc = 8'(aprod / 16'(dsp_pkg::PERCENT_FULL)); // R15
    nxt_dec = 8'(dprod / 16'(dsp_pkg::PERCENT_FULL)); // R15
    nxt_st = st_ff;
    nxt_job_valid = job_valid_ff;
    nxt_tgt = tgt_ff;
    nxt_vcmd = 32'sh0000_0000;
    nxt_start = 1'b0;
    nxt_fault = 1'b0;
    // R11 Continuous relative is refused and flagged
    if (c.cont && !absolute && !c.setup) nxt_fault = 1'b1;
    if (!abs_ok && !c.setup) nxt_fault = 1'b1; // R6
    if (!c.enable || !c.discard_n) begin // R1
      nxt_st = c.enable ? dsp_pkg::ST_STOP : dsp_pkg::ST_IDLE; // R5
      nxt_job_valid = 1'b0; // R5
    end else if (!c.istop_n) begin
      if (job_valid_ff) nxt_st = dsp_pkg::ST_HOLD; // R4
    end else begin
      case (st_ff)
        dsp_pkg::ST_IDLE, dsp_pkg::ST_STOP: begin
          if (c.setup) begin
            nxt_st = dsp_pkg::ST_MOVE; // R2
            nxt_job_valid = 1'b1;
          end else if ((edge_start || (c.cont && absolute)) // R9 R10
                       && !nxt_fault) begin
            nxt_st = dsp_pkg::ST_MOVE;
            nxt_job_valid = 1'b1;
            nxt_start = edge_start;
            nxt_tgt = absolute ? pos_sel : 32'(tgt_ff + pos_sel); // R6
          end
        end
        dsp_pkg::ST_HOLD: nxt_st = dsp_pkg::ST_MOVE; // R4
        dsp_pkg::ST_MOVE: begin
          // R3 Mode may drop to positioning with no stop
          if (!c.setup && (edge_start || c.cont) && !nxt_fault) begin
            nxt_start = edge_start;
            nxt_tgt = absolute ? pos_sel : 32'(tgt_ff + pos_sel); // R10
          end
        end
        default: nxt_st = dsp_pkg::ST_IDLE;
      endcase
    end
    if (nxt_st == dsp_pkg::ST_MOVE) begin
      if (c.setup) begin
        // R7 Bit 6 positive, bit 7 negative
        if (!dir_stop) begin
          nxt_vcmd = c.dir_neg ? -$signed(vscaled) : $signed(vscaled);
        end
      end else if (rot_dir) begin
        nxt_vcmd = rot_neg ? -$signed(vscaled) : $signed(vscaled); // R13
      end else begin
        nxt_vcmd = $signed(vscaled);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= dsp_pkg::RST_CTRL;
      pos_ff <= '0;
      vel_ff <= '0;
      ovr_ff <= dsp_pkg::RST_OVR;
      adapt_ff <= '0;
      src_ff <= '0;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rd_ff <= '0;
      fix_wait_ff <= 1'b0;
      fix_pos_ff <= '0;
      fix_vel_ff <= '0;
      fix_ovr_ff <= dsp_pkg::RST_OVR;
      accept_q_ff <= 1'b0;
      st_ff <= dsp_pkg::ST_IDLE;
      job_valid_ff <= 1'b0;
      tgt_ff <= '0;
      vcmd_ff <= '0;
      acc_ff <= '0;
      dec_ff <= '0;
      start_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pos_ff <= nxt_pos;
      vel_ff <= nxt_vel;
      ovr_ff <= nxt_ovr;
      adapt_ff <= nxt_adapt;
      src_ff <= nxt_src;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      rd_ff <= nxt_rd;
      fix_wait_ff <= nxt_fix_wait;
      fix_pos_ff <= nxt_fix_pos;
      fix_vel_ff <= nxt_fix_vel;
      fix_ovr_ff <= nxt_fix_ovr;
      accept_q_ff <= nxt_accept_q; // R17
      st_ff <= nxt_st;
      job_valid_ff <= nxt_job_valid;
      tgt_ff <= nxt_tgt;
      vcmd_ff <= nxt_vcmd;
      acc_ff <= nxt_acc;
      dec_ff <= nxt_dec;
      start_ff <= nxt_start;
      fault_ff <= nxt_fault;
    end
  end

  assign wb_dat_o = rd_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  // One-hot state: bit 1 is the MOVE flop, so no decode gate on the pin
  assign move_active = st_ff[1];
  assign target_pos = tgt_ff;
  assign vel_cmd = vcmd_ff;
  assign accel_cmd = acc_ff;
  assign decel_cmd = dec_ff;
  assign start_pulse = start_ff;
  assign cmd_fault = fault_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_hold_on_stop: assert property ( // R4
    c.enable && c.discard_n && !c.istop_n && job_valid_ff
    |=> st_ff == dsp_pkg::ST_HOLD && vcmd_ff == 0)
    else $error("Intermediate stop did not hold the axis");
  a_discard_kills: assert property ( // R5
    c.enable && !c.discard_n |=> !job_valid_ff && vcmd_ff == 0)
    else $error("Discard left the job valid");
  a_dir_equal_stop: assert property ( // R8
    c.setup && dir_stop |=> vcmd_ff == 0)
    else $error("Equal direction bits did not stop");
  a_start_one_cycle: assert property ( // R17
    start_pulse |=> !start_pulse)
    else $error("Start pulse wider than one cycle");
  a_start_needs_edge: assert property ( // R9
    $rose(start_pulse) |-> $past(c.accept) && !$past(accept_q_ff)
    && !$past(c.cont))
    else $error("Start without accept rise");
  a_no_abs_unref: assert property ( // R6
    !c.setup && c.enable && absolute && !c.referenced |=> cmd_fault)
    else $error("Absolute move allowed unreferenced");
  a_cont_rel_flag: assert property ( // R11
    c.cont && !absolute && !c.setup |=> cmd_fault)
    else $error("Continuous relative not flagged");
  a_cont_tracks: assert property ( // R10
    move_active && c.enable && c.istop_n && c.discard_n && c.cont
    && !c.setup && absolute && abs_ok |=> target_pos == $past(pos_sel))
    else $error("Continuous mode did not track setpoint");
  a_disable_idle: assert property ( // R1
    !c.enable |=> st_ff == dsp_pkg::ST_IDLE)
    else $error("Axis active without enable");
  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held more than one cycle");
  c_edge_start: cover property (start_pulse);
  c_hold: cover property (st_ff == dsp_pkg::ST_HOLD);
  c_setup_move: cover property (move_active && c.setup && vcmd_ff != 0);
  c_setup_to_pos: cover property (move_active && $fell(c.setup));
endmodule

// ==== testbench/dsp_ctl_model.sv ====
// Purpose: Machine control model driving the positioner over Wishbone
// Assumes: Classic single cycles, one idle cycle between requests
// Notes: Control writes always carry the enable bit
`timescale 1ns/1ns
module dsp_ctl_model (
  // Clock
  input wire logic clk_sys,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  input wire logic wb_err_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0000_0000;
  end
  // One bus cycle; waits for ack or err, the bench timeout cuts a hang
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    do @(posedge clk_sys);
    while (wb_ack_i !== 1'b1 && wb_err_i !== 1'b1);
    q = wb_dat_i;
    e = wb_err_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    // Released data is inverted so a stale value never looks live
    wb_dat_o <= ~d;
  endtask
  // Control word; bad lets a scenario break the continuous-mode rule
  task automatic ctl(input logic [31:0] b, input logic bad);
    logic [31:0] v;
    logic [31:0] q;
    logic e;
    v = b;
    v[dsp_pkg::B_ENABLE] = 1'b1;
    if (b[dsp_pkg::B_CONT] && !bad) v[dsp_pkg::B_ABS] = 1'b1;
    xfer(1'b1, dsp_pkg::OFS_CTRL, v, q, e);
  endtask
endmodule

// ==== testbench/dsp_core_tb.sv ====
// Purpose: Self-checking bench for the direct setpoint positioner
// Assumes: 125 MHz clock, async active-low reset
// Notes: Settle of four edges covers the two-edge start latency
`timescale 1ns/1ns
module dsp_core_tb;
  logic clk_sys, rstn, cyc, stb, we, ack, err, e;
  logic move_active, start_pulse, cmd_fault;
  logic [7:0] adr, accel_cmd, decel_cmd;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, target_pos, q;
  logic signed [31:0] vel_cmd;
  int failures, comparisons, cycles, starts, st0;
  localparam logic [31:0] B = 32'h0000_000C;
  localparam logic [31:0] SU = 32'h2, AB = 32'h10, AC = 32'h100;
  localparam logic [31:0] CO = 32'h200, RF = 32'h400;
  logic [31:0] dirs [4] = '{32'h40, 32'h80, 32'hC0, 32'h0};
  logic [31:0] vexp [4] = '{32'd1000, -32'sd1000, 32'h0, 32'h0};

  dsp_core u_dsp_core (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .move_active(move_active), .target_pos(target_pos),
    .vel_cmd(vel_cmd), .accel_cmd(accel_cmd), .decel_cmd(decel_cmd),
    .start_pulse(start_pulse), .cmd_fault(cmd_fault));
  dsp_ctl_model u_dsp_ctl_model (.clk_sys(clk_sys), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
    .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_err_i(err));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Start pulses are counted, so a two-cycle pulse shows as two starts
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (start_pulse === 1'b1) starts <= starts + 1;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_dsp_ctl_model.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    u_dsp_ctl_model.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic go(input logic [31:0] b, input logic bad);
    u_dsp_ctl_model.ctl(b, bad);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    starts = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk(32'(move_active), 32'h0);
    chk(target_pos, 32'h0);
    chk(vel_cmd, 32'h0);
    chk(32'(cmd_fault), 32'h0);
    rd(dsp_pkg::OFS_CTRL);
    chk(q, dsp_pkg::RST_CTRL);
    rd(dsp_pkg::OFS_OVR);
    chk(q, dsp_pkg::RST_OVR);
    rd(8'h40);
    chk(32'(e), 32'h1);
    wr(8'h18, 32'h0000_00FF);
    chk(32'(e), 32'h1);
    // Edge start, relative, held accept gives no second start
    wr(dsp_pkg::OFS_POS, 32'd100);
    go(B, 1'b0);
    go(B | AC, 1'b0);
    chk(starts, 1);
    chk(target_pos, 32'd100);
    chk(32'(move_active), 32'h1);
    go(B | AC, 1'b0);
    chk(starts, 1);
    go(B, 1'b0);
    wr(dsp_pkg::OFS_POS, 32'd50);
    go(B | AC, 1'b0);
    chk(target_pos, 32'd150);
    // Intermediate stop keeps the job, discard kills it
    go(32'h108, 1'b0);
    chk(32'(move_active), 32'h0);
    chk(vel_cmd, 32'h0);
    rd(dsp_pkg::OFS_STATUS);
    chk(32'(q[4:0]), 32'h14);
    go(B | AC, 1'b0);
    chk(32'(move_active), 32'h1);
    chk(starts, 2);
    go(32'h104 | AC, 1'b0);
    rd(dsp_pkg::OFS_STATUS);
    chk(32'(q[4:0]), 32'h08);
    go(B | AC, 1'b0);
    chk(32'(move_active), 32'h0);
    go(B, 1'b0);
    go(B | AC, 1'b0);
    chk(target_pos, 32'd200);
    chk(starts, 3);
    // Absolute needs the reference
    wr(dsp_pkg::OFS_POS, 32'd300);
    go(B | AB, 1'b0);
    chk(32'(cmd_fault), 32'h1);
    go(B | AB | AC, 1'b0);
    chk(starts, 3);
    go(B | AB | RF, 1'b0);
    chk(32'(cmd_fault), 32'h0);
    go(B | AB | RF | AC, 1'b0);
    chk(target_pos, 32'd300);
    // Continuous acceptance
    go(B | CO, 1'b1);
    chk(32'(cmd_fault), 32'h1);
    go(B | CO | RF, 1'b0);
    chk(32'(cmd_fault), 32'h0);
    wr(dsp_pkg::OFS_POS, 32'd444);
    repeat (4) @(posedge clk_sys);
    chk(target_pos, 32'd444);
    st0 = starts;
    go(B | CO | RF | AC, 1'b0);
    chk(starts, st0);
    go(B | AB | RF, 1'b0);
    // Adaptation digit overrides the type bit; digits 2 and 3 still start
    for (int d = 0; d < 4; d++) begin
      wr(dsp_pkg::OFS_ADAPT, 32'h0100 | (32'(d) << 4));
      wr(dsp_pkg::OFS_POS, 32'd10);
      st0 = starts;
      go(B | AB | RF | AC, 1'b0);
      chk(starts, st0 + 1);
      if (d == 0) chk(target_pos, 32'd10);
      if (d == 1) chk(target_pos, 32'd20);
      go(B | AB | RF, 1'b0);
    end
    wr(dsp_pkg::OFS_ADAPT, 32'h0);
    go(B | AB | RF | AC, 1'b0);
    chk(target_pos, 32'd10);
    go(B | RF, 1'b0);
    go(B | RF | AC, 1'b0);
    chk(target_pos, 32'd20);
    // Stored fixed position
    wr(dsp_pkg::OFS_FIX_BASE, 32'd777);
    rd(dsp_pkg::OFS_FIX_BASE);
    chk(q, 32'd777);
    wr(dsp_pkg::OFS_SRC, 32'h1);
    go(B | AB | RF, 1'b0);
    go(B | AB | RF | AC, 1'b0);
    chk(target_pos, 32'd777);
    wr(dsp_pkg::OFS_SRC, 32'h0);
    // Set-up direction, equal bits stop, overrides
    wr(dsp_pkg::OFS_VEL, 32'd1000);
    // Velocity override resets to zero percent; set full scale first
    wr(dsp_pkg::OFS_OVR, 32'h0064_6464);
    for (int i = 0; i < 4; i++) begin
      go(B | SU | dirs[i], 1'b0);
      chk(vel_cmd, vexp[i]);
    end
    wr(dsp_pkg::OFS_OVR, 32'h0019_3228);
    go(B | SU | 32'h40, 1'b0);
    chk(vel_cmd, 32'd500);
    chk(32'(accel_cmd), 32'h28);
    chk(32'(decel_cmd), 32'h19);
    // Switch from set-up to positioning while moving
    st0 = starts;
    go(B | AB | RF | AC, 1'b0);
    chk(starts, st0 + 1);
    chk(target_pos, 32'd10);
    // Rotary digit signs the positioning velocity
    chk(vel_cmd, 32'd500);
    wr(dsp_pkg::OFS_ADAPT, 32'h0000_0030);
    repeat (2) @(posedge clk_sys);
    chk(vel_cmd, -32'sd500);
    wr(dsp_pkg::OFS_ADAPT, 32'h0000_0020);
    repeat (2) @(posedge clk_sys);
    chk(vel_cmd, 32'd500);
    test_done();
  end
endmodule
